// *** src/seg_xlate.sv ***
/*
 * first-level translation stage: descriptor sets, validity checks, table
 * address forming, translation cache, thread level and page tracking.
 * assumes an external walker answers each table fetch with the final frame.
 */
// Implementation choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
module seg_xlate
	import seg_xlate_pkg::*;
#(
	parameter int CIW           = 5,
	parameter bit REDUCED       = 1'b0,
	parameter int CACHE_ENTRIES = 8
) (
	input  wire logic                clk_i,
	input  wire logic                rst_n_i,
	input  wire logic                ce_i,
	input  wire logic [5:0]          avs_address_i,
	input  wire logic                avs_read_i,
	input  wire logic                avs_write_i,
	input  wire logic [31:0]         avs_writedata_i,
	input  wire logic [3:0]          avs_byteenable_i,
	output logic [31:0]              avs_readdata_o,
	output logic                     avs_waitrequest_o,
	input  wire logic                req_valid_i,
	output logic                     req_ready_o,
	input  wire logic [31:0]         req_vaddr_i,
	input  wire logic                req_write_i,
	input  wire logic                req_channel_i,
	output logic                     done_o,
	output logic [FRAME_W-1:0]       phys_frame_o,
	output logic                     fetch_valid_o,
	output logic [31:0]              fetch_addr_o,
	output logic [THREAD_W-1:0]      fetch_thread_o,
	input  wire logic                fill_valid_i,
	input  wire logic [FRAME_W-1:0]  fill_frame_i,
	output logic                     ctx_save_o,
	output logic                     exception_o,
	output logic                     code_load_o,
	output logic [31:0]              address_register_five_o,
	output logic                     process_monitor_enable_o,
	input  wire logic                enter_i,
	input  wire logic                leave_i,
	output logic                     thread_valid_o,
	output logic [THREAD_W-1:0]      thread_ident_o
);
	localparam int SETS  = 1 << CIW;
	localparam int WORDS = SETS * SEG_COUNT;
	localparam int KEY_W = CIW + THREAD_W + FRAME_W;

	if (CIW != 3 && CIW != 5) begin : g_ciw_chk
		$error("communication index must be 3 or 5 bits");
	end
	if ((1 << (VA_IDX_HI - VA_IDX_LO + 1)) * 4 != TABLE_BYTES
		|| SEG_COUNT * TABLE_BYTES != FRAME_BYTES) begin : g_tab_chk
		$error("first-level table size does not fit the frame");
	end
	if ((64'd1 << VA_SEG_LO) != SEG_SPAN) begin : g_seg_chk
		$error("segment span must be 512 mbyte");
	end

	typedef struct packed {
		logic [WORDS-1:0][31:0]       desc;
		logic [31:0]                  ctrl;
		logic [CIW-1:0]               index;
		logic [31:0]                  pool;
		logic [TRACK_COUNT-1:0]       refd;
		logic [TRACK_COUNT-1:0]       modf;
		logic                         ack;
		logic [31:0]                  rdata;
		xlate_state_type              fsm;
		logic [31:0]                  va;
		logic                         wr;
		logic                         chan;
		logic [7:0]                   code;
		logic                         done;
		logic [FRAME_W-1:0]           frame;
		logic [31:0]                  fetch_addr;
		logic                         ctx;
		logic                         exc;
		logic                         code_load;
		logic [31:0]                  code_word;
		logic                         monitor;
	} top_state_type;

	top_state_type          st;
	top_state_type          next_st;
	logic                   thr_busy;
	logic [THREAD_W-1:0]    thr_ident;
	logic                   mp;
	logic [31:0]            cur_desc;
	logic                   seg_valid;
	logic                   chan_ok;
	logic                   bus_req;
	logic [3:0]             word;
	logic [FRAME_W-1:0]     hit_frame;

	cache_link_if #(.KEY_W(KEY_W)) link ();

	translation_cache #(
		.ENTRIES(CACHE_ENTRIES),
		.KEY_W  (KEY_W)
	) u_cache (
		.clk_i  (clk_i),
		.rst_n_i(rst_n_i),
		.ce_i   (ce_i),
		.link   (link.cache)
	);

	thread_pool #(
		.REDUCED(REDUCED)
	) u_pool (
		.clk_i  (clk_i),
		.rst_n_i(rst_n_i),
		.ce_i   (ce_i),
		.pool_i (st.pool),
		.enter_i(enter_i),
		.leave_i(leave_i),
		.busy_o (thr_busy),
		.ident_o(thr_ident)
	);

	// descriptor of the segment under translation, from the active set
	assign mp = st.ctrl[CTRL_MP_BIT];
	assign cur_desc = st.desc[{st.index, st.va[31:VA_SEG_LO]}];
	assign seg_valid = mp ? st.desc[{st.index, st.va[31:VA_SEG_LO]}][MP_VALID_BIT]
		: cur_desc[SC_VALID_BIT];
	assign chan_ok = !st.chan || (mp && cur_desc[MP_CHANNEL_BIT]);
	assign bus_req = avs_read_i || avs_write_i;
	assign word = avs_address_i[5:2];

	// cache key: process set, thread and virtual page keep unshared pages apart
	assign link.key = {st.index, thr_ident, st.va[31:PAGE_LO]};
	assign link.fill = st.fsm == S_FETCH && fill_valid_i;
	assign link.fill_frame = fill_frame_i;
	assign link.flush = st.ack && avs_write_i && avs_address_i < OFS_CTRL;
	assign hit_frame = link.frame;

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		next_st.ctx = 1'b0;
		next_st.exc = 1'b0;
		next_st.code_load = 1'b0;

		// one wait state on every access while ce_i is high; the answer lands on the ack cycle
		next_st.ack = bus_req && !st.ack;
		if (bus_req && !st.ack) begin
			next_st.rdata = '0;
			if (avs_address_i < OFS_CTRL) begin
				next_st.rdata = st.desc[{st.index, word[2:0]}];
			end else begin
				case (avs_address_i)
					OFS_CTRL: begin
						next_st.rdata = st.ctrl;
					end
					OFS_INDEX: begin
						next_st.rdata = 32'(st.index);
					end
					OFS_POOL: begin
						next_st.rdata = st.pool;
					end
					OFS_STATUS: begin
						next_st.rdata = {16'h0000, st.code, 2'b00, thr_busy, thr_ident};
					end
					OFS_REF: begin
						next_st.rdata = st.refd;
					end
					OFS_MOD: begin
						next_st.rdata = st.modf;
					end
					default: begin
						next_st.rdata = '0;
					end
				endcase
			end
		end

		// register writes take effect on the ack cycle only
		if (st.ack && avs_write_i) begin
			if (avs_address_i < OFS_CTRL) begin
				next_st.desc[{st.index, word[2:0]}] = merge_bytes(
					st.desc[{st.index, word[2:0]}], avs_writedata_i, avs_byteenable_i);
			end else begin
				case (avs_address_i)
					OFS_CTRL: begin
						next_st.ctrl = merge_bytes(st.ctrl, avs_writedata_i, avs_byteenable_i);
					end
					OFS_INDEX: begin
						if (avs_byteenable_i[0]) begin
							next_st.index = avs_writedata_i[CIW-1:0];
						end
					end
					OFS_POOL: begin
						next_st.pool = merge_bytes(st.pool, avs_writedata_i, avs_byteenable_i);
					end
					OFS_REF: begin
						next_st.refd = st.refd & ~merge_bytes('0, avs_writedata_i, avs_byteenable_i);
					end
					OFS_MOD: begin
						next_st.modf = st.modf & ~merge_bytes('0, avs_writedata_i, avs_byteenable_i);
					end
					default: begin
					end
				endcase
			end
		end

		case (st.fsm)
			S_IDLE: begin
				if (req_valid_i && thr_busy) begin
					next_st.va = req_vaddr_i;
					next_st.wr = req_write_i;
					next_st.chan = req_channel_i;
					next_st.fsm = S_LOOK;
				end
			end
			S_LOOK: begin
				next_st.monitor = mp && cur_desc[MP_MONITOR_BIT];
				// no table fetch is issued for a bad segment
				if (!seg_valid || !chan_ok) begin
					next_st.code = seg_valid ? ERR_CHANNEL : ERR_SEG_INVALID;
					next_st.fsm = S_SAVE;
				end else if (link.hit) begin
					next_st.frame = hit_frame;
					next_st.done = 1'b1;
					next_st.fsm = S_IDLE;
				end else begin
					next_st.fetch_addr = table_addr(cur_desc, st.va, mp);
					next_st.fsm = S_FETCH;
				end
			end
			S_FETCH: begin
				if (fill_valid_i) begin
					next_st.frame = fill_frame_i;
					next_st.done = 1'b1;
					next_st.fsm = S_IDLE;
				end
			end
			S_SAVE: begin
				next_st.ctx = 1'b1;
				next_st.fsm = S_RAISE;
			end
			S_RAISE: begin
				next_st.exc = 1'b1;
				next_st.fsm = S_LOAD;
			end
			S_LOAD: begin
				next_st.code_load = 1'b1;
				next_st.code_word = {24'h000000, st.code};
				next_st.fsm = S_IDLE;
			end
			default: begin
				next_st.fsm = S_IDLE;
			end
		endcase

		// page tracking; hardware set beats a software clear in the same cycle
		if (next_st.done) begin
			next_st.refd[next_st.frame[4:0]] = 1'b1;
			if (st.wr) begin
				next_st.modf[next_st.frame[4:0]] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st <= '0;
			st.ctrl <= CTRL_RESET;
			st.pool <= POOL_RESET;
			st.fsm <= S_IDLE;
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	assign avs_waitrequest_o = bus_req && !st.ack;
	assign avs_readdata_o = st.rdata;
	assign req_ready_o = st.fsm == S_IDLE && thr_busy;
	assign done_o = st.done;
	assign phys_frame_o = st.frame;
	assign fetch_valid_o = st.fsm == S_FETCH;
	assign fetch_addr_o = st.fetch_addr;
	assign fetch_thread_o = thr_ident;
	assign ctx_save_o = st.ctx;
	assign exception_o = st.exc;
	assign code_load_o = st.code_load;
	assign address_register_five_o = st.code_word;
	assign process_monitor_enable_o = st.monitor;
	assign thread_valid_o = thr_busy;
	assign thread_ident_o = thr_ident;
endmodule // seg_xlate

// *** shared/seg_xlate_pkg.sv ***
/*
 * constants, types and helpers for the segment descriptor translation stage.
 * assumes a single clock, synchronous reset and an avalon-mm register slave.
 */
package seg_xlate_pkg;
	localparam int SEG_COUNT   = 8;
	localparam int THREAD_W    = 5;
	localparam int FRAME_W     = 20;
	localparam int TRACK_COUNT = 32;
	localparam int TABLE_BYTES = 512;
	localparam int FRAME_BYTES = 4096;
	localparam logic [63:0] SEG_SPAN = 64'h0000_0000_2000_0000;

	// register byte offsets
	localparam logic [5:0] OFS_DESC   = 6'h00;
	localparam logic [5:0] OFS_CTRL   = 6'h20;
	localparam logic [5:0] OFS_INDEX  = 6'h24;
	localparam logic [5:0] OFS_POOL   = 6'h28;
	localparam logic [5:0] OFS_STATUS = 6'h2c;
	localparam logic [5:0] OFS_REF    = 6'h30;
	localparam logic [5:0] OFS_MOD    = 6'h34;

	// reset values
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] POOL_RESET = 32'h0000_0000;

	// field positions
	localparam int CTRL_MP_BIT    = 0;
	localparam int SC_VALID_BIT   = 31;
	localparam int SC_BASE_HI     = 29;
	localparam int MP_BASE_HI     = 31;
	localparam int BASE_LO        = 9;
	localparam int MP_MONITOR_BIT = 7;
	localparam int MP_CHANNEL_BIT = 6;
	localparam int MP_VALID_BIT   = 4;
	localparam int VA_SEG_LO      = 29;
	localparam int VA_IDX_HI      = 28;
	localparam int VA_IDX_LO      = 22;
	localparam int PAGE_LO        = 12;
	localparam int STAT_CODE_LO   = 8;
	localparam int STAT_BUSY_BIT  = 5;

	// error codes handed to address register five
	localparam logic [7:0] ERR_SEG_INVALID = 8'h01;
	localparam logic [7:0] ERR_CHANNEL     = 8'h02;

	typedef enum logic [5:0] {
		S_IDLE  = 6'b000001,
		S_LOOK  = 6'b000010,
		S_FETCH = 6'b000100,
		S_SAVE  = 6'b001000,
		S_RAISE = 6'b010000,
		S_LOAD  = 6'b100000
	} xlate_state_type;

	// merge write data into a word under the avalon byte enables
	function automatic logic [31:0] merge_bytes(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = data[8*i +: 8];
			end
		end
		return r;
	endfunction

	// physical address of the first-level table entry
	function automatic logic [31:0] table_addr(input logic [31:0] desc,
		input logic [31:0] va, input logic mp);
		logic [31:0] base;
		base = mp ? {desc[MP_BASE_HI:BASE_LO], 9'h000}
			: {2'b00, desc[SC_BASE_HI:BASE_LO], 9'h000};
		return base | {23'h000000, va[VA_IDX_HI:VA_IDX_LO], 2'b00};
	endfunction
endpackage

// *** shared/cache_link_if.sv ***
/*
 * lookup and fill path between the translation stage and its cache.
 * assumes both ends sit on the same clock.
 */
`timescale 1ns/1ns
interface cache_link_if #(parameter int KEY_W = 30) ();
	logic [KEY_W-1:0] key;
	logic             hit;
	logic [19:0]      frame;
	logic             fill;
	logic [19:0]      fill_frame;
	logic             flush;

	modport stage (output key, fill, fill_frame, flush, input hit, frame);
	modport cache (input key, fill, fill_frame, flush, output hit, frame);
endinterface // cache_link_if

// *** src/translation_cache.sv ***
/*
 * fully associative cache of recent translations, round-robin refill.
 * assumes lookups are combinational and fills come one per cycle.
 */
`timescale 1ns/1ns
module translation_cache
	import seg_xlate_pkg::*;
#(
	parameter int ENTRIES = 8,
	parameter int KEY_W   = 30
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic ce_i,
	cache_link_if.cache link
);
	localparam int PW = $clog2(ENTRIES);

	if (ENTRIES < 2 || (ENTRIES & (ENTRIES - 1)) != 0) begin : g_chk
		$error("cache entries must be a power of two of at least two");
	end

	typedef struct packed {
		logic [ENTRIES-1:0]              valid;
		logic [ENTRIES-1:0][KEY_W-1:0]   key;
		logic [ENTRIES-1:0][FRAME_W-1:0] frame;
		logic [PW-1:0]                   ptr;
	} cache_state_type;

	cache_state_type st;
	cache_state_type next_st;

	// hidden from software: only a descriptor change flushes it
	always_comb begin
		link.hit = 1'b0;
		link.frame = '0;
		for (int i = 0; i < ENTRIES; i++) begin
			if (st.valid[i] && st.key[i] == link.key) begin
				link.hit = 1'b1;
				link.frame = st.frame[i];
			end
		end
	end

	always_comb begin
		next_st = st;
		if (link.flush) begin
			next_st.valid = '0;
		end else if (link.fill) begin
			next_st.valid[st.ptr] = 1'b1;
			next_st.key[st.ptr] = link.key;
			next_st.frame[st.ptr] = link.fill_frame;
			next_st.ptr = st.ptr + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st <= '0;
		end else if (ce_i) begin
			st <= next_st;
		end
	end
endmodule // translation_cache

// *** src/thread_pool.sv ***
/*
 * hands out thread identifiers from the pool software prepared.
 * assumes enter and leave are one-cycle pulses, never together.
 */
`timescale 1ns/1ns
module thread_pool
	import seg_xlate_pkg::*;
#(
	parameter bit REDUCED = 1'b0
) (
	input  wire logic                clk_i,
	input  wire logic                rst_n_i,
	input  wire logic                ce_i,
	input  wire logic [31:0]         pool_i,
	input  wire logic                enter_i,
	input  wire logic                leave_i,
	output logic                     busy_o,
	output logic [THREAD_W-1:0]      ident_o
);
	typedef struct packed {
		logic                busy;
		logic [THREAD_W-1:0] ident;
	} pool_state_type;

	pool_state_type st;
	pool_state_type next_st;
	logic [31:0]    usable;

	// the reduced variant can only reach eight identifiers
	assign usable = REDUCED ? (pool_i & 32'h0000_00ff) : pool_i;

	// lowest free identifier wins; an empty pool leaves the cpu idle
	always_comb begin
		next_st = st;
		if (leave_i) begin
			next_st.busy = 1'b0;
		end else if (enter_i && !st.busy) begin
			for (int i = 31; i >= 0; i--) begin
				if (usable[i]) begin
					next_st.busy = 1'b1;
					next_st.ident = 5'(i);
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st <= '0;
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	assign busy_o = st.busy;
	assign ident_o = st.ident;
endmodule // thread_pool

// *** tb/seg_xlate_props.sv ***
/*
 * concurrent checks on the translation stage ports.
 * assumes one clock and a synchronous low reset; clock enable may drop.
 */
`timescale 1ns/1ns
module seg_xlate_props
	import seg_xlate_pkg::*;
(
	input wire logic                clk_i,
	input wire logic                rst_n_i,
	input wire logic                ce_i,
	input wire logic                avs_read_i,
	input wire logic                avs_write_i,
	input wire logic                avs_waitrequest_o,
	input wire logic                req_valid_i,
	input wire logic                req_ready_o,
	input wire logic [31:0]         req_vaddr_i,
	input wire logic                done_o,
	input wire logic [FRAME_W-1:0]  phys_frame_o,
	input wire logic                fetch_valid_o,
	input wire logic [31:0]         fetch_addr_o,
	input wire logic [THREAD_W-1:0] fetch_thread_o,
	input wire logic                fill_valid_i,
	input wire logic [FRAME_W-1:0]  fill_frame_i,
	input wire logic                ctx_save_o,
	input wire logic                exception_o,
	input wire logic                code_load_o,
	input wire logic                leave_i,
	input wire logic                thread_valid_o,
	input wire logic [THREAD_W-1:0] thread_ident_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// every access sees exactly one wait state while ce_i is high
	bus_stall_a: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
		else $error("bus request not stalled in its first cycle");
	bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i
		|=> !avs_waitrequest_o)
		else $error("bus request stalled beyond one wait state");
	// fault sequence runs save, raise, load on consecutive cycles
	fault_order_a: assert property (ctx_save_o |=> exception_o ##1 code_load_o)
		else $error("fault pulses out of order");
	fault_nofetch_a: assert property (ctx_save_o |-> !fetch_valid_o [*3])
		else $error("table fetch during a segment fault");
	fill_done_a: assert property (fill_valid_i && fetch_valid_o
		|=> done_o && phys_frame_o == $past(fill_frame_i))
		else $error("walker answer not returned as the frame");
	fetch_addr_a: assert property (fetch_valid_o
		|-> fetch_addr_o[8:0] == {req_vaddr_i[28:22], 2'b00})
		else $error("table entry address low bits wrong");
	fetch_thread_a: assert property (fetch_valid_o
		|-> thread_valid_o && fetch_thread_o == thread_ident_o)
		else $error("fetch carries a foreign thread");
	ready_thread_a: assert property (req_ready_o |-> thread_valid_o)
		else $error("request accepted without a thread");
	thread_drop_a: assert property (leave_i && ce_i |=> !thread_valid_o)
		else $error("thread kept after leaving");
endmodule // seg_xlate_props

bind seg_xlate seg_xlate_props props (.*);

// *** tb/walker_model.sv ***
/*
 * table walker stand-in: answers each first-level fetch with a frame.
 * assumes fetch_valid_i stays high until the fill pulse has been seen.
 */
`timescale 1ns/1ns
module walker_model (
	input  wire logic        clk_i,
	input  wire logic        fetch_valid_i,
	input  wire logic [31:0] fetch_addr_i,
	input  wire logic [3:0]  lag_i,
	output logic             fill_valid_o,
	output logic [19:0]      fill_frame_o,
	output int               fetches_o
);
	int wait_n = 0;
	initial begin
		fill_valid_o = 1'b0;
		fill_frame_o = 20'h00000;
		fetches_o = 0;
	end
	// answer after lag_i idle cycles; the frame bus churns outside the pulse
	always @(posedge clk_i) begin
		fill_valid_o <= 1'b0;
		fill_frame_o <= ~fill_frame_o;
		if (fetch_valid_i && !fill_valid_o) begin
			if (wait_n >= int'(lag_i)) begin
				fill_valid_o <= 1'b1;
				fill_frame_o <= fetch_addr_i[31:12] ^ 20'h0abc3;
				fetches_o <= fetches_o + 1;
				wait_n <= 0;
			end else begin
				wait_n <= wait_n + 1;
			end
		end
	end
endmodule // walker_model

// *** tb/seg_xlate_bench.sv ***
/*
 * self-checking bench: register access over avalon, translations, faults.
 * assumes the walker model on the fetch side and the bound checker.
 */
`timescale 1ns/1ns
module seg_xlate_bench;
	import seg_xlate_pkg::*;
	logic clk_i, rst_n_i, ce_i, avs_read_i, avs_write_i, avs_waitrequest_o;
	logic req_valid_i, req_ready_o, req_write_i, req_channel_i, done_o;
	logic fetch_valid_o, fill_valid_i, ctx_save_o, exception_o, code_load_o;
	logic process_monitor_enable_o, enter_i, leave_i, thread_valid_o;
	logic [5:0]          avs_address_i;
	logic [3:0]          avs_byteenable_i, lag;
	logic [31:0]         avs_writedata_i, avs_readdata_o, req_vaddr_i, fetch_addr_o;
	logic [31:0]         address_register_five_o, q, d, va, slot, taddr;
	logic [FRAME_W-1:0]  phys_frame_o, fill_frame_i, frame;
	logic [THREAD_W-1:0] fetch_thread_o, thread_ident_o;
	logic                saw_done, saw_exc;
	int                  n_fail = 0, checked = 0, fetches, f0;

	seg_xlate dut (.*);
	walker_model walker (.clk_i(clk_i), .fetch_valid_i(fetch_valid_o),
		.fetch_addr_i(fetch_addr_o), .lag_i(lag), .fill_valid_o(fill_valid_i),
		.fill_frame_o(fill_frame_i), .fetches_o(fetches));

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_up(input string what);
		n_fail++;
		$display("CHECK FAILED timeout %s expected answer seen none", what);
		final_report();
	endtask
	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] dat);
		int n;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= dat;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		if (n >= 50) give_up("waitrequest");
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask
	task automatic rd_chk(input string what, input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(what, q, exp);
	endtask
	// one translation request; vaddr stays put until the next request
	task automatic xlate(input logic [31:0] v, input logic w, input logic ch);
		int n;
		@(posedge clk_i);
		req_vaddr_i <= v;
		req_write_i <= w;
		req_channel_i <= ch;
		req_valid_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (req_ready_o !== 1'b1 && n < 50);
		if (n >= 50) give_up("ready");
		req_valid_i <= 1'b0;
		saw_exc = 1'b0;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
			if (exception_o === 1'b1) saw_exc = 1'b1;
		end while (done_o !== 1'b1 && code_load_o !== 1'b1 && n < 100);
		if (n >= 100) give_up("translation");
		saw_done = done_o;
		frame = phys_frame_o;
		@(posedge clk_i);
	endtask
	task automatic pulse(input logic ent);
		@(posedge clk_i);
		if (ent) enter_i <= 1'b1;
		else leave_i <= 1'b1;
		@(posedge clk_i);
		enter_i <= 1'b0;
		leave_i <= 1'b0;
		@(posedge clk_i);
	endtask

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	initial begin
		{rst_n_i, avs_read_i, avs_write_i, req_valid_i, req_write_i} = '0;
		{req_channel_i, enter_i, leave_i, lag, avs_address_i} = '0;
		{avs_writedata_i, req_vaddr_i} = '0;
		ce_i = 1'b1;
		avs_byteenable_i = 4'hf;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// reset values, unmapped place, descriptor storage in set 0
		check("ready no thread", req_ready_o, 32'h0);
		rd_chk("ctrl reset", OFS_CTRL, CTRL_RESET);
		rd_chk("pool reset", OFS_POOL, POOL_RESET);
		rd_chk("unmapped", 6'h38, 32'h0);
		for (int i = 0; i < 8; i++) bus(1'b1, 6'(4 * i), 32'(i) * 32'h1010_1010 ^ 32'h1ff);
		for (int i = 0; i < 8; i++) rd_chk("desc", 6'(4 * i), 32'(i) * 32'h1010_1010 ^ 32'h1ff);
		// a five-bit set index selects a separate descriptor set
		bus(1'b1, OFS_INDEX, 32'h11);
		bus(1'b1, OFS_DESC, 32'h5555_5555);
		rd_chk("desc set 17", OFS_DESC, 32'h5555_5555);
		bus(1'b1, OFS_INDEX, 32'h0);
		rd_chk("desc set 0", OFS_DESC, 32'h1ff);
		// byte lanes: only the enabled low half of the word is replaced
		avs_byteenable_i <= 4'h3;
		bus(1'b1, OFS_DESC, 32'haaaa_aaaa);
		avs_byteenable_i <= 4'hf;
		rd_chk("desc bytes", OFS_DESC, 32'h0000_aaaa);
		// thread allocation takes the lowest free identifier
		bus(1'b1, OFS_POOL, 32'h110);
		pulse(1'b1);
		check("thread valid", thread_valid_o, 32'h1);
		check("thread ident", thread_ident_o, 32'h4);
		// single-cpu miss with a slow walker; bit 30 and bits 8..7 written as zero
		d = 32'h8abc_de7f;
		va = 32'h4f80_1234;
		bus(1'b1, 6'h08, d);
		lag = 4'h3;
		xlate(va, 1'b0, 1'b0);
		taddr = {2'b00, d[29:9], va[28:22], 2'b00};
		check("sc done", saw_done, 32'h1);
		check("sc frame", frame, taddr[31:12] ^ 20'h0abc3);
		slot = 32'h1 << frame[4:0];
		rd_chk("ref set", OFS_REF, slot);
		rd_chk("mod clear", OFS_MOD, 32'h0);
		// repeat as a write: served from the cache, marks the frame modified
		f0 = fetches;
		xlate(va, 1'b1, 1'b0);
		check("hit fetches", fetches, f0);
		check("hit frame", frame, taddr[31:12] ^ 20'h0abc3);
		rd_chk("mod set", OFS_MOD, slot);
		bus(1'b1, OFS_MOD, slot);
		rd_chk("mod w1c", OFS_MOD, 32'h0);
		// single-cpu invalid segment faults without touching memory
		bus(1'b1, 6'h0c, 32'h0);
		f0 = fetches;
		xlate(32'h6000_0000, 1'b0, 1'b0);
		check("sc fault", saw_exc, 32'h1);
		check("sc code", address_register_five_o, {24'h0, ERR_SEG_INVALID});
		check("no fetch", fetches, f0);
		// multi-cpu format with a prompt walker, monitor and channel bits
		bus(1'b1, OFS_CTRL, 32'h1);
		d = 32'hfedc_b1d0;
		va = 32'ha1c0_0000;
		bus(1'b1, 6'h14, d);
		lag = 4'h0;
		xlate(va, 1'b0, 1'b1);
		check("mp done", saw_done, 32'h1);
		check("mp frame", frame, d[31:12] ^ 20'h0abc3);
		check("monitor on", process_monitor_enable_o, 32'h1);
		bus(1'b1, 6'h14, 32'hfedc_b190);
		xlate(va, 1'b0, 1'b1);
		check("channel code", address_register_five_o, {24'h0, ERR_CHANNEL});
		bus(1'b1, 6'h18, 32'h1234_5680);
		xlate(32'hc000_0000, 1'b0, 1'b0);
		check("mp invalid", address_register_five_o, {24'h0, ERR_SEG_INVALID});
		bus(1'b1, 6'h14, 32'hfedc_b050);
		xlate(va, 1'b0, 1'b0);
		check("monitor off", process_monitor_enable_o, 32'h0);
		// a leave pulse while the clock enable is low must not release the thread
		ce_i <= 1'b0;
		pulse(1'b0);
		check("frozen thread", thread_valid_o, 32'h1);
		ce_i <= 1'b1;
		pulse(1'b0);
		check("thread gone", thread_valid_o, 32'h0);
		final_report();
	end
endmodule // seg_xlate_bench
